// File: design/epm_core.sv
`timescale 1ns/1ps
// How it works
// - Reset is vector 1, rank -3; pending at reset, retired after first instruction.
// - NMI is vector 2, rank -2; only reset outranks it.
// - NMI has no hardware source; software set only.
// - Hard fault vector 3, rank -1; taken for blocked or disabled faults.
// - Memory management vector 4, settable, on protection mismatch.
// - Bus fault vector 5, settable, enable controlled; precise or imprecise.
// - Usage fault vector 6, settable, on undefined instruction or bad state.
// - Service call vector 11, settable, on service instruction.
// - Debug monitor vector 12, only when enabled and more urgent than active.
// - Pendable service request vector 14, software pended only.
// - System tick vector 15, raised when the tick timer fires.
// - Peripheral lines map to vectors 16 upward, prioritised here.
// - All settable priorities reset to zero.
// - Only documented peripheral bits are implemented; 9-13, 26-27 and 30-31 reserved.
// - Eight levels; user level 0 ranks just below the three fixed ones.
// - Equal levels: lower position wins.
module epm_core
  import epm_pkg::*;
#(
  parameter int NUM_IRQ = EPM_NUM_IRQ
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic first_instr_in,
  input epm_events_t events_in,
  input epm_ctrl_t ctrl_in,
  input wire logic [NUM_IRQ-1:0] irq_in,
  input wire logic [NUM_IRQ-1:0] irq_enable_in,
  input wire logic prio_we_in,
  input wire logic [5:0] prio_vec_in,
  input wire logic [EPM_PRIO_W-1:0] prio_data_in,
  input wire logic ack_in,
  input wire logic [5:0] ack_vec_in,
  input wire logic ret_in,
  input wire logic [4:0] ret_rank_in,
  output epm_req_t req_out,
  output logic [4:0] active_rank_out
);

  localparam int NC = 16 + NUM_IRQ;

  // Maps a 3-bit user level to the internal rank above the fixed ones.
  function automatic logic [4:0] epm_rank(input logic [EPM_PRIO_W-1:0] lvl);
    epm_rank = EPM_RANK_USER0 + {2'h0, lvl};
  endfunction : epm_rank

  // Vector position of a settable system handler, by handler index.
  function automatic logic [5:0] epm_sh_pos(input int idx);
    unique case (idx)
      0: epm_sh_pos = EPM_POS_MEM;
      1: epm_sh_pos = EPM_POS_BUS;
      2: epm_sh_pos = EPM_POS_USAGE;
      3: epm_sh_pos = EPM_POS_SVC;
      4: epm_sh_pos = EPM_POS_DBG;
      5: epm_sh_pos = EPM_POS_PSR;
      6: epm_sh_pos = EPM_POS_TICK;
      default: epm_sh_pos = EPM_POS_NONE;
    endcase
  endfunction : epm_sh_pos

  logic reset_pend;
  logic nmi_pend;
  logic hard_pend;
  logic [6:0] sys_pend;
  logic [6:0] sys_set;
  logic [NUM_IRQ-1:0] irq_pend;
  logic [EPM_PRIO_W-1:0] sh_prio [7];
  logic [EPM_PRIO_W-1:0] irq_prio [NUM_IRQ];
  logic [4:0] active_rank;
  logic [NC-1:0] cand_pend;
  logic [NC*5-1:0] cand_rank;
  logic [NC*6-1:0] cand_pos;
  epm_req_t best;
  logic [6:0] fault_raw;
  logic [6:0] fault_ok;
  logic escalate;

  // Which fault inputs fire and whether their own handler could take them.
  always_comb begin
    fault_raw = '0;
    fault_raw[EPM_SH_MEM] = events_in.mpu_mismatch;
    fault_raw[EPM_SH_BUS] = events_in.bus_fault;
    fault_raw[EPM_SH_USAGE] = events_in.usage_fault;
    fault_ok = '0;
    fault_ok[EPM_SH_MEM] = ctrl_in.mem_fault_en && epm_rank(sh_prio[EPM_SH_MEM]) < active_rank;
    fault_ok[EPM_SH_BUS] = ctrl_in.bus_fault_en &&
      (!events_in.bus_precise || epm_rank(sh_prio[EPM_SH_BUS]) < active_rank);
    fault_ok[EPM_SH_USAGE] = ctrl_in.usage_fault_en && epm_rank(sh_prio[EPM_SH_USAGE]) < active_rank;
    escalate = |(fault_raw & ~fault_ok);
  end

  // Reset exception pends at reset and retires at the first instruction.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_pend <= 1'b1;
    end else if (first_instr_in) begin
      reset_pend <= 1'b0;
    end
  end

  // Fixed-priority pending flags; a new event wins over an acknowledge.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nmi_pend <= 1'b0;
      hard_pend <= 1'b0;
    end else begin
      nmi_pend <= ctrl_in.nmi_set || (nmi_pend && !(ack_in && ack_vec_in == EPM_POS_NMI));
      hard_pend <= escalate || (hard_pend && !(ack_in && ack_vec_in == EPM_POS_HARD));
    end
  end

  // Set conditions of the settable system handlers.
  always_comb begin
    sys_set = '0;
    sys_set[EPM_SH_MEM] = events_in.mpu_mismatch && fault_ok[EPM_SH_MEM];
    sys_set[EPM_SH_BUS] = events_in.bus_fault && fault_ok[EPM_SH_BUS];
    sys_set[EPM_SH_USAGE] = events_in.usage_fault && fault_ok[EPM_SH_USAGE];
    sys_set[EPM_SH_SVC] = events_in.svc_exec;
    sys_set[EPM_SH_DBG] = events_in.debug_event && ctrl_in.debug_mon_en &&
      epm_rank(sh_prio[EPM_SH_DBG]) < active_rank;
    sys_set[EPM_SH_PSR] = ctrl_in.psr_set;
    sys_set[EPM_SH_TICK] = events_in.tick_fire;
  end

  // Settable system handler pending flags; a new event wins over an acknowledge.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sys_pend <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        sys_pend[i] <= sys_set[i] || (sys_pend[i] && !(ack_in && ack_vec_in == epm_sh_pos(i)));
      end
    end
  end

  // Peripheral lines latch while enabled; unimplemented bits never pend.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_pend <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        irq_pend[i] <= EPM_IRQ_IMPL[i] && irq_enable_in[i] && (irq_in[i] ||
          (irq_pend[i] && !(ack_in && ack_vec_in == 6'(16 + i))));
      end
    end
  end

  // Priority storage, written by the core, cleared at reset.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 7; i++) sh_prio[i] <= EPM_PRIO_RESET;
      for (int i = 0; i < NUM_IRQ; i++) irq_prio[i] <= EPM_PRIO_RESET;
    end else if (prio_we_in) begin
      for (int i = 0; i < 7; i++) begin
        if (prio_vec_in == epm_sh_pos(i)) begin
          sh_prio[i] <= prio_data_in;
        end
      end
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (prio_vec_in == 6'(16 + i)) irq_prio[i] <= prio_data_in;
      end
    end
  end

  // Active rank follows acknowledges and returns; idle after reset.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_rank <= EPM_RANK_IDLE;
    end else if (ack_in && best.valid) begin
      active_rank <= best.rank;
    end else if (ret_in) begin
      active_rank <= ret_rank_in;
    end
  end

  // Candidate table in position order.
  always_comb begin
    cand_pend = '0;
    cand_rank = '1;
    cand_pos = '0;
    cand_pend[1] = reset_pend;
    cand_rank[1*5 +: 5] = EPM_RANK_RESET;
    cand_pos[1*6 +: 6] = EPM_POS_RESET;
    cand_pend[2] = nmi_pend;
    cand_rank[2*5 +: 5] = EPM_RANK_NMI;
    cand_pos[2*6 +: 6] = EPM_POS_NMI;
    cand_pend[3] = hard_pend;
    cand_rank[3*5 +: 5] = EPM_RANK_HARD;
    cand_pos[3*6 +: 6] = EPM_POS_HARD;
    for (int i = 0; i < 7; i++) begin
      cand_pend[epm_sh_pos(i)] = sys_pend[i];
      cand_rank[epm_sh_pos(i)*5 +: 5] = epm_rank(sh_prio[i]);
      cand_pos[epm_sh_pos(i)*6 +: 6] = epm_sh_pos(i);
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      cand_pend[16 + i] = irq_pend[i];
      cand_rank[(16 + i)*5 +: 5] = epm_rank(irq_prio[i]);
      cand_pos[(16 + i)*6 +: 6] = 6'(16 + i);
    end
  end

  epm_pick #(.N(NC)) u_pick (
    .pend_in(cand_pend),
    .rank_in(cand_rank),
    .pos_in(cand_pos),
    .best_out(best)
  );

  // Registered answer: only a winner more urgent than the active one is offered.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_out <= '{valid: 1'b0, vector: EPM_POS_NONE, rank: EPM_RANK_IDLE};
      active_rank_out <= EPM_RANK_IDLE;
    end else begin
      req_out.valid <= best.valid && best.rank < active_rank;
      req_out.vector <= best.vector;
      req_out.rank <= best.rank;
      active_rank_out <= active_rank;
    end
  end

endmodule : epm_core

// File: design/epm_pick.sv
`timescale 1ns/1ps
// Picks the most urgent of a set of candidates; ties go to the lower position.
module epm_pick
  import epm_pkg::*;
#(
  parameter int N = 48
) (
  input wire logic [N-1:0] pend_in,
  input wire logic [N*5-1:0] rank_in,
  input wire logic [N*6-1:0] pos_in,
  output epm_req_t best_out
);

  // Linear scan in ascending position order; strict less keeps the earlier one.
  always_comb begin
    best_out = '{valid: 1'b0, vector: EPM_POS_NONE, rank: EPM_RANK_IDLE};
    for (int i = 0; i < N; i++) begin
      if (pend_in[i] && (!best_out.valid || rank_in[i*5 +: 5] < best_out.rank)) begin
        best_out.valid = 1'b1;
        best_out.rank = rank_in[i*5 +: 5];
        best_out.vector = pos_in[i*6 +: 6];
      end
    end
  end

endmodule : epm_pick

// File: design/epm_pkg.sv
package epm_pkg;

  // Vector positions of the system exceptions.
  localparam logic [5:0] EPM_POS_RESET = 6'h01;
  localparam logic [5:0] EPM_POS_NMI = 6'h02;
  localparam logic [5:0] EPM_POS_HARD = 6'h03;
  localparam logic [5:0] EPM_POS_MEM = 6'h04;
  localparam logic [5:0] EPM_POS_BUS = 6'h05;
  localparam logic [5:0] EPM_POS_USAGE = 6'h06;
  localparam logic [5:0] EPM_POS_SVC = 6'h0B;
  localparam logic [5:0] EPM_POS_DBG = 6'h0C;
  localparam logic [5:0] EPM_POS_PSR = 6'h0E;
  localparam logic [5:0] EPM_POS_TICK = 6'h0F;
  localparam logic [5:0] EPM_POS_EXT0 = 6'h10;
  localparam logic [5:0] EPM_POS_NONE = 6'h00;

  // Number of peripheral interrupt lines and the mask of implemented ones.
  localparam int EPM_NUM_IRQ = 32;
  localparam logic [31:0] EPM_IRQ_IMPL = 32'h33FFC1FF;

  // Priority levels, 3 bits give eight settable levels.
  localparam int EPM_PRIO_W = 3;
  localparam logic [2:0] EPM_PRIO_RESET = 3'h0;

  // Fixed priorities encoded in a 5-bit rank: lower is more urgent.
  localparam logic [4:0] EPM_RANK_RESET = 5'h00;
  localparam logic [4:0] EPM_RANK_NMI = 5'h01;
  localparam logic [4:0] EPM_RANK_HARD = 5'h02;
  localparam logic [4:0] EPM_RANK_USER0 = 5'h03;
  localparam logic [4:0] EPM_RANK_IDLE = 5'h1F;

  // Indices of the seven settable system handlers.
  typedef enum logic [2:0] {
    EPM_SH_MEM, EPM_SH_BUS, EPM_SH_USAGE, EPM_SH_SVC, EPM_SH_DBG, EPM_SH_PSR, EPM_SH_TICK
  } epm_sh_t;

  // Raw system events from the core.
  typedef struct packed {
    logic mpu_mismatch;
    logic bus_fault;
    logic bus_precise;
    logic usage_fault;
    logic svc_exec;
    logic debug_event;
    logic tick_fire;
  } epm_events_t;

  // Software control from the core's system control writes.
  typedef struct packed {
    logic nmi_set;
    logic psr_set;
    logic bus_fault_en;
    logic mem_fault_en;
    logic usage_fault_en;
    logic debug_mon_en;
  } epm_ctrl_t;

  // Answer towards the core.
  typedef struct packed {
    logic valid;
    logic [5:0] vector;
    logic [4:0] rank;
  } epm_req_t;

endpackage : epm_pkg

// File: verif/epm_core_chk.sv
`timescale 1ns/1ps
// Watches the answer towards the core for rank, vector and ordering slips.
module epm_core_chk
  import epm_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input epm_ctrl_t ctrl_in,
  input wire logic ack_in,
  input wire logic [5:0] ack_vec_in,
  input epm_req_t req_out,
  input wire logic [4:0] active_rank_out
);
  logic nmi_seen;
  logic [4:0] ack_rank;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // Remembers a software request for the non-maskable interrupt and the rank last taken.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nmi_seen <= 1'b0;
      ack_rank <= 5'h1F;
    end else begin
      nmi_seen <= nmi_seen | ctrl_in.nmi_set;
      ack_rank <= ack_in ? req_out.rank : ack_rank;
    end
  end
  chk_reset_rank:
    assert property (req_out.valid && req_out.vector == EPM_POS_RESET |-> req_out.rank == EPM_RANK_RESET)
    else $error("reset vector has wrong rank");
  chk_nmi_rank:
    assert property (req_out.valid && req_out.vector == EPM_POS_NMI |-> req_out.rank == EPM_RANK_NMI)
    else $error("nmi vector has wrong rank");
  chk_nmi_source:
    assert property (req_out.valid && req_out.vector == EPM_POS_NMI |-> nmi_seen)
    else $error("nmi offered without a software request");
  chk_hard_rank:
    assert property (req_out.valid && req_out.vector == EPM_POS_HARD |-> req_out.rank == EPM_RANK_HARD)
    else $error("hard fault vector has wrong rank");
  chk_settable_rank:
    assert property (req_out.valid && req_out.vector > EPM_POS_HARD |-> req_out.rank inside {[5'h03:5'h0A]})
    else $error("settable vector outside user ranks");
  chk_vector_legal:
    assert property (req_out.valid |-> req_out.vector inside {[6'h01:6'h06], 6'h0B, 6'h0C, [6'h0E:6'h2F]})
    else $error("vector on a reserved position");
  chk_irq_reserved:
    assert property (req_out.valid && req_out.vector >= EPM_POS_EXT0 |->
      EPM_IRQ_IMPL[5'(req_out.vector - EPM_POS_EXT0)])
    else $error("vector of an unimplemented line");
  chk_ack_active:
    assert property (ack_in && req_out.valid && ack_vec_in == req_out.vector |-> ##[1:2] active_rank_out == ack_rank)
    else $error("active rank not taken from the winner");
  chk_offer_urgent:
    assert property (req_out.valid && !$past(ack_in) && !$past(ack_in, 2) |-> req_out.rank < active_rank_out)
    else $error("offered vector does not outrank the active one");
endmodule : epm_core_chk

bind epm_core epm_core_chk i_chk (.clock_in(clock_in), .arst_n_in(arst_n_in), .ctrl_in(ctrl_in),
  .ack_in(ack_in), .ack_vec_in(ack_vec_in), .req_out(req_out), .active_rank_out(active_rank_out));

// File: verif/epm_core_model.sv
`timescale 1ns/1ps
// Core side: takes the offered vector after a short or long think.
module epm_core_model
  import epm_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic slow_in,
  input epm_req_t req_in,
  output logic ack_out,
  output logic [5:0] ack_vec_out
);
  logic [2:0] wait_cnt;
  logic [2:0] hold;
  // After each take it pauses so the old answer clears; the vector lines are scrambled when idle.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_out <= 1'b0;
      ack_vec_out <= 6'h3F;
      wait_cnt <= 3'h0;
      hold <= 3'h0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      ack_vec_out <= ~ack_vec_out;
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else if (req_in.valid && wait_cnt >= (slow_in ? 3'h3 : 3'h0)) begin
      ack_out <= 1'b1;
      ack_vec_out <= req_in.vector;
      wait_cnt <= 3'h0;
    end else if (req_in.valid) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule : epm_core_model

// File: verif/test_exception_priority_map.sv
`timescale 1ns/1ps
// Raises exceptions and lines, and checks which vector and rank the core is handed.
module test_exception_priority_map
  import epm_pkg::*;
;
  localparam epm_ctrl_t BASE = 6'h0F;
  logic clock_in = 1'b0, arst_n_in = 1'b0, first_instr_in = 1'b0, prio_we_in = 1'b0, ret_in = 1'b0, slow = 1'b0;
  epm_events_t events_in = '0;
  epm_ctrl_t ctrl_in = BASE;
  logic [31:0] irq_in = '0, irq_enable_in = '1;
  logic [5:0] prio_vec_in = '0, ack_vec_in;
  logic [2:0] prio_data_in = '0;
  logic [4:0] ret_rank_in = 5'h1F, active_rank_out;
  logic ack_in;
  epm_req_t req_out;
  int err_count = 0, compares = 0, n, k;
  logic [6:0] ev_t [11] = '{7'h00, 7'h40, 7'h40, 7'h30, 7'h30, 7'h08, 7'h04, 7'h02, 7'h02, 7'h00, 7'h01};
  logic [5:0] ct_t [11] = '{6'h2F, 6'h0F, 6'h0B, 6'h0F, 6'h07, 6'h0F, 6'h0F, 6'h0F, 6'h0E, 6'h1F, 6'h0F};
  logic [5:0] vec_t [11] = '{6'h02, 6'h04, 6'h03, 6'h05, 6'h03, 6'h06, 6'h0B, 6'h0C, 6'h00, 6'h0E, 6'h0F};
  logic [4:0] rk_t [11] = '{5'h01, 5'h03, 5'h02, 5'h03, 5'h02, 5'h03, 5'h03, 5'h03, 5'h00, 5'h03, 5'h03};
  epm_core i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .first_instr_in(first_instr_in),
    .events_in(events_in), .ctrl_in(ctrl_in), .irq_in(irq_in), .irq_enable_in(irq_enable_in),
    .prio_we_in(prio_we_in), .prio_vec_in(prio_vec_in), .prio_data_in(prio_data_in), .ack_in(ack_in),
    .ack_vec_in(ack_vec_in), .ret_in(ret_in), .ret_rank_in(ret_rank_in), .req_out(req_out),
    .active_rank_out(active_rank_out));
  epm_core_model i_core (.clock_in(clock_in), .arst_n_in(arst_n_in), .slow_in(slow), .req_in(req_out),
    .ack_out(ack_in), .ack_vec_out(ack_vec_in));
  // Free-running clock.
  always #5 clock_in = ~clock_in;
  function automatic logic [4:0] rank_of(input logic [2:0] lvl);
    return EPM_RANK_USER0 + 5'(lvl);
  endfunction : rank_of
  function automatic logic [5:0] irq_vec(input int b);
    return EPM_POS_EXT0 + 6'(b);
  endfunction : irq_vec
  task automatic complete_run;
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic cmp_vec(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t vector %0h want %0h", $time, got, exp);
    end
  endtask : cmp_vec
  task automatic cmp_rank(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t rank %0h want %0h", $time, got, exp);
    end
  endtask : cmp_rank
  // Waits for the core to take a vector (none expected when vec is zero), then returns to idle.
  task automatic take(input logic [5:0] vec, input logic [4:0] rk);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 30 && !got; i++) begin
      @(negedge clock_in);
      if (ack_in === 1'b1) begin
        got = 1'b1;
        cmp_vec(req_out.vector, vec);
        cmp_rank(req_out.rank, rk);
      end
    end
    if (!got) cmp_vec(6'h00, vec);
    repeat (2) @(negedge clock_in);
    if (got) cmp_rank(active_rank_out, rk);
    ret_in = 1'b1;
    @(negedge clock_in);
    ret_in = 1'b0;
  endtask : take
  task automatic fire(input logic [6:0] ev, input logic [5:0] ct, input logic [31:0] irq);
    @(negedge clock_in);
    events_in = ev;
    ctrl_in = ct;
    irq_in = irq;
    slow = 1'($urandom);
    @(negedge clock_in);
    events_in = '0;
    ctrl_in = BASE;
    irq_in = '0;
  endtask : fire
  task automatic prio(input logic [5:0] v, input logic [2:0] d);
    @(negedge clock_in);
    prio_we_in = 1'b1;
    prio_vec_in = v;
    prio_data_in = d;
    @(negedge clock_in);
    prio_we_in = 1'b0;
  endtask : prio
  // Main sequence.
  initial begin
    void'($urandom(32'hDA43A7CD));
    repeat (2) @(negedge clock_in);
    arst_n_in = 1'b1;
    take(EPM_POS_RESET, EPM_RANK_RESET);
    first_instr_in = 1'b1;
    @(negedge clock_in);
    first_instr_in = 1'b0;
    for (k = 0; k < 11; k++) begin
      fire(ev_t[k], ct_t[k], '0);
      take(vec_t[k], rk_t[k]);
    end
    do n = $urandom_range(31, 0); while (!EPM_IRQ_IMPL[n]);
    fire('0, BASE, 32'h1 << n);
    take(irq_vec(n), rank_of(3'h0));
    fire('0, BASE, 32'hCC003E00);
    take(6'h00, 5'h00);
    prio(EPM_POS_TICK, 3'h2);
    fire(7'h01, BASE, '0);
    take(EPM_POS_TICK, rank_of(3'h2));
    prio(irq_vec(0), 3'h5);
    prio(irq_vec(1), 3'h5);
    fire('0, BASE, 32'h3);
    take(irq_vec(0), rank_of(3'h5));
    take(irq_vec(1), rank_of(3'h5));
    prio(irq_vec(2), 3'h7);
    prio(irq_vec(3), 3'h1);
    fire('0, BASE, 32'hC);
    take(irq_vec(3), rank_of(3'h1));
    take(irq_vec(2), rank_of(3'h7));
    complete_run();
  end
  // Cuts a hang short.
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule : test_exception_priority_map
